// ### hw/uies_pkg.sv
// Package with constants and types of the interrupt enable and status block.
//
// Behaviour
// R1 - FIFO mode: receive interrupt follows trigger level
// R2 - Data ready sets on push, clears when empty
// R3 - FIFO on, enables 0-3 clear: polled mode
// R4 - Line status bits 1-7 report errors, empties
// R5 - Enable bit 0 gates receive ready interrupt
// R6 - Enable bit 1 gates transmit ready interrupt
// R7 - Enable bit 2 gates line status interrupt
// R8 - Mode bit 6: error interrupt at FIFO entry
// R9 - Enable bit 3 gates modem status interrupt
// R10 - Enable bits 4,5 writable only when enhanced; code locks bits 4-7 unless enhanced
// R11 - Bits 6,7: RTS/CTS rising edge interrupts
// R12 - Status shows one highest pending, others queued
// R13 - Status codes encode seven priority levels
// R14 - Timeout after four chars plus twelve bits
// R15 - Transmit ready cleared by status read, write
// R16 - Line, modem reads clear their interrupts
// R17 - Host reads until level below trigger
// R18 - Xon/Xoff/special interrupts and their clearing
// R19 - Wake-up interrupt cleared by status read
// R20 - GPIO interrupt cleared by level read
// R21 - Status bit 7 FIFO on, bit 6 GPIO; code gives bit 6 as FIFO on xor GPIO pending
// R22 - Interrupt output active while anything pending
package uies_pkg;

  // ==========================================================================
  // Register offsets and reset values.
  localparam logic [2:0] uies_ofs_interrupt_enable = 3'h1;
  localparam logic [2:0] uies_ofs_interrupt_status = 3'h2;
  localparam logic [7:0] uies_rst_interrupt_enable = 8'h00;
  localparam logic [7:0] uies_rst_interrupt_status = 8'h01;
  localparam logic [7:0] uies_rst_line_status      = 8'h60;

  // ==========================================================================
  // Field positions of the enable register.
  localparam int uies_ie_rx     = 0;
  localparam int uies_ie_tx     = 1;
  localparam int uies_ie_line   = 2;
  localparam int uies_ie_modem  = 3;
  localparam int uies_ie_sleep  = 4;
  localparam int uies_ie_xoff   = 5;
  localparam int uies_ie_rts    = 6;
  localparam int uies_ie_cts    = 7;
  localparam logic [7:0] uies_ie_enhanced_mask = 8'hf0;

  // ==========================================================================
  // Field positions of the status and line status registers.
  localparam int uies_is_gpio   = 6;
  localparam int uies_is_fifo   = 7;
  localparam int uies_ls_ready  = 0;
  localparam int uies_ls_over   = 1;
  localparam int uies_ls_err_lo = 2;
  localparam int uies_ls_thr    = 5;
  localparam int uies_ls_temt   = 6;
  localparam int uies_ls_fifo   = 7;

  // ==========================================================================
  // Status codes, highest priority first.
  localparam logic [5:0] uies_code_line    = 6'h06;
  localparam logic [5:0] uies_code_timeout = 6'h0c;
  localparam logic [5:0] uies_code_rx      = 6'h04;
  localparam logic [5:0] uies_code_tx      = 6'h02;
  localparam logic [5:0] uies_code_modem   = 6'h00;
  localparam logic [5:0] uies_code_special = 6'h10;
  localparam logic [5:0] uies_code_flow    = 6'h20;
  localparam logic [5:0] uies_code_none    = 6'h01;

  // ==========================================================================
  // Receive timeout length, in characters and bits.
  localparam int unsigned uies_timeout_chars = 4;
  localparam int unsigned uies_timeout_bits  = 12;
  localparam int unsigned uies_gpio_width    = 8;

  // ==========================================================================
  // Carriers.
  typedef struct packed {
    logic [7:0] level;
    logic [7:0] trigger;
    logic       push;
    logic [2:0] push_err;
    logic       pop;
    logic       hold_load;
    logic [2:0] hold_err;
    logic       overrun;
    logic       any_err;
  } uies_rx_type;

  typedef struct packed {
    logic [7:0] level;
    logic [7:0] trigger;
    logic       holding_empty;
    logic       shift_empty;
  } uies_tx_type;

  typedef struct packed {
    logic       enhanced;
    logic       auto_rts;
    logic       auto_cts;
    logic       error_at_entry;
    logic       wake_enable;
  } uies_cfg_type;

  typedef enum logic [1:0] {
    uies_tmr_idle  = 2'b00,
    uies_tmr_count = 2'b01,
    uies_tmr_fired = 2'b11
  } uies_tmr_type;

endpackage : uies_pkg

// ### hw/uies_sync.sv
// Two flip-flop synchroniser for pin inputs.
`timescale 1ns/100ps
`default_nettype none
module uies_sync #(
  parameter int unsigned width = 1
) (
  input  wire logic             clock,
  input  wire logic             rst,
  input  wire logic [width-1:0] pin,
  output logic      [width-1:0] level
);

  // ==========================================================================
  // Synchroniser stages.
  logic [width-1:0] stage;

  always_ff @(posedge clock) begin
    if (rst) begin
      stage <= '0;
      level <= '0;
    end else begin
      stage <= pin;
      level <= stage;
    end
  end

endmodule : uies_sync
`default_nettype wire

// ### hw/uies_timeout.sv
// Receive timeout timer counting bit times while data waits.
`timescale 1ns/100ps
`default_nettype none
module uies_timeout (
  input  wire logic       clock,
  input  wire logic       rst,
  input  wire logic       bit_tick,
  input  wire logic [3:0] char_bits,
  input  wire logic       waiting,
  input  wire logic       activity,
  output logic            fire
);

  // ==========================================================================
  // Counter and state.
  uies_pkg::uies_tmr_type state;
  logic [7:0]             count;
  logic [7:0]             limit;

  assign limit = 8'(char_bits) * 8'(uies_pkg::uies_timeout_chars) + 8'(uies_pkg::uies_timeout_bits);

  always_ff @(posedge clock) begin
    if (rst) begin
      state <= uies_pkg::uies_tmr_idle;
      count <= 8'h00;
      fire  <= 1'b0;
    end else begin
      fire <= 1'b0;
      if (!waiting || activity) begin
        state <= waiting ? uies_pkg::uies_tmr_count : uies_pkg::uies_tmr_idle;
        count <= 8'h00;
      end else begin
        case (state)
          uies_pkg::uies_tmr_idle: begin
            state <= uies_pkg::uies_tmr_count;
          end
          uies_pkg::uies_tmr_count: begin
            if (bit_tick) begin
              count <= count + 8'h01;
              if (count + 8'h01 >= limit) begin
                state <= uies_pkg::uies_tmr_fired;
                fire  <= 1'b1; // [R14]
              end
            end
          end
          uies_pkg::uies_tmr_fired: begin
            state <= uies_pkg::uies_tmr_fired;
          end
          default: begin
            state <= uies_pkg::uies_tmr_idle;
          end
        endcase
      end
    end
  end

endmodule : uies_timeout
`default_nettype wire

// ### hw/uies_top.sv
// Interrupt enable, line status and prioritised interrupt status logic.
`timescale 1ns/100ps
`default_nettype none
module uies_top (
  input  wire logic                       clock,
  input  wire logic                       rst,
  input  wire logic [2:0]                 reg_addr,
  input  wire logic                       reg_wr,
  input  wire logic                       reg_rd,
  input  wire logic [7:0]                 reg_wdata,
  input  wire logic                       line_status_rd,
  input  wire logic                       modem_status_rd,
  input  wire logic                       receive_holding_rd,
  input  wire logic                       transmit_holding_wr,
  input  wire logic                       gpio_level_rd,
  input  wire logic                       fifo_enable,
  input  wire uies_pkg::uies_rx_type      rx,
  input  wire uies_pkg::uies_tx_type      tx,
  input  wire uies_pkg::uies_cfg_type     cfg,
  input  wire logic [3:0]                 modem_status,
  input  wire logic                       bit_tick,
  input  wire logic [3:0]                 char_bits,
  input  wire logic                       rts_out,
  input  wire logic                       cts_pin,
  input  wire logic                       xon_match,
  input  wire logic                       xoff_match,
  input  wire logic                       special_match,
  input  wire logic                       wake_event,
  input  wire logic [7:0]                 gpio_pin,
  input  wire logic [7:0]                 gpio_int_enable,
  input  wire logic [7:0]                 gpio_inversion,
  output logic [7:0]                      interrupt_enable,
  output logic [7:0]                      interrupt_status,
  output logic [7:0]                      line_status,
  output logic                            polled_mode,
  output logic                            sleep_enable,
  output logic                            irq
);

  // ==========================================================================
  // Priority encoder over the pending sources.
  function automatic logic [5:0] uies_encode(input logic [6:0] pend);
    logic [5:0] code;
    code = uies_pkg::uies_code_none;
    if (pend[0]) begin
      code = uies_pkg::uies_code_line;
    end else if (pend[1]) begin
      code = uies_pkg::uies_code_timeout;
    end else if (pend[2]) begin
      code = uies_pkg::uies_code_rx;
    end else if (pend[3]) begin
      code = uies_pkg::uies_code_tx;
    end else if (pend[4]) begin
      code = uies_pkg::uies_code_modem;
    end else if (pend[5]) begin
      code = uies_pkg::uies_code_special;
    end else if (pend[6]) begin
      code = uies_pkg::uies_code_flow;
    end
    return code;
  endfunction : uies_encode

  // ==========================================================================
  // Pin synchronisers and edge history.
  logic       cts_sync;
  logic [7:0] gpio_sync;
  logic       cts_prev;
  logic       rts_prev;
  logic [7:0] gpio_prev;
  logic       tx_below_prev;
  logic       timeout_fire;

  uies_sync #(.width(1)) u_cts_sync (
    .clock (clock),
    .rst   (rst),
    .pin   (cts_pin),
    .level (cts_sync)
  );

  uies_sync #(.width(uies_pkg::uies_gpio_width)) u_gpio_sync (
    .clock (clock),
    .rst   (rst),
    .pin   (gpio_pin),
    .level (gpio_sync)
  );

  uies_timeout u_timeout (
    .clock     (clock),
    .rst       (rst),
    .bit_tick  (bit_tick),
    .char_bits (char_bits),
    .waiting   (rx.level != 8'h00),
    .activity  (rx.push | rx.pop),
    .fire      (timeout_fire)
  );

  // ==========================================================================
  // Access decode and combinational event terms.
  logic       ie_write;
  logic       is_read;
  logic       rx_level_pend;
  logic       tx_below;
  logic       tx_event;
  logic       line_event;
  logic [7:0] gpio_active;
  logic [7:0] gpio_rise;
  logic       flow_event;
  logic [6:0] pend;
  logic [5:0] current_code;
  logic       gpio_pend;

  assign ie_write = reg_wr && (reg_addr == uies_pkg::uies_ofs_interrupt_enable);
  assign is_read  = reg_rd && (reg_addr == uies_pkg::uies_ofs_interrupt_status);

  // Receive ready is a level: trigger reached in FIFO mode, a character held otherwise.
  assign rx_level_pend = fifo_enable ? (rx.level >= rx.trigger) : (rx.level != 8'h00); // [R1] [R5] [R17]

  assign tx_below = fifo_enable ? (tx.level < tx.trigger) || (tx.level == 8'h00) : tx.holding_empty;
  // Falling below the trigger, emptying, or enabling while already below the trigger or empty.
  assign tx_event = (tx_below && !tx_below_prev)
                  || (ie_write && reg_wdata[uies_pkg::uies_ie_tx]
                      && !interrupt_enable[uies_pkg::uies_ie_tx] && tx_below); // [R6] [R15]

  // Overrun at once; character errors at entry or at the holding position.
  assign line_event = rx.overrun
                    || (cfg.error_at_entry ? (rx.push && (rx.push_err != 3'h0)) // [R8]
                                           : (rx.hold_load && (rx.hold_err != 3'h0))); // [R7]

  assign gpio_active = (gpio_sync ^ gpio_inversion) & gpio_int_enable; // [R20]
  assign gpio_rise   = gpio_active & ~gpio_prev;

  assign flow_event = (interrupt_enable[uies_pkg::uies_ie_rts] && cfg.auto_rts && rts_out && !rts_prev)
                    || (interrupt_enable[uies_pkg::uies_ie_cts] && cfg.auto_cts && cts_sync && !cts_prev); // [R11]

  // ==========================================================================
  // Edge history.
  always_ff @(posedge clock) begin
    if (rst) begin
      cts_prev      <= 1'b0;
      rts_prev      <= 1'b0;
      gpio_prev     <= 8'hff;
      tx_below_prev <= 1'b1;
    end else begin
      cts_prev      <= cts_sync;
      rts_prev      <= rts_out;
      gpio_prev     <= gpio_active;
      tx_below_prev <= tx_below;
    end
  end

  // ==========================================================================
  // Enable register.
  always_ff @(posedge clock) begin
    if (rst) begin
      interrupt_enable <= uies_pkg::uies_rst_interrupt_enable;
    end else if (ie_write) begin
      if (cfg.enhanced) begin
        interrupt_enable <= reg_wdata; // [R10]
      end else begin
        interrupt_enable <= (reg_wdata & ~uies_pkg::uies_ie_enhanced_mask)
                          | (interrupt_enable & uies_pkg::uies_ie_enhanced_mask); // [R10]
      end
    end
  end

  // ==========================================================================
  // Line status register.
  logic data_ready;
  logic overrun_flag;

  always_ff @(posedge clock) begin
    if (rst) begin
      data_ready <= 1'b0;
    end else if (rx.push) begin
      data_ready <= 1'b1; // [R2]
    end else if (rx.level == 8'h00) begin
      data_ready <= 1'b0; // [R2]
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      overrun_flag <= 1'b0;
    end else if (rx.overrun) begin
      overrun_flag <= 1'b1;
    end else if (line_status_rd) begin
      overrun_flag <= 1'b0;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      line_status <= uies_pkg::uies_rst_line_status;
    end else begin
      line_status[uies_pkg::uies_ls_ready]                       <= data_ready;
      line_status[uies_pkg::uies_ls_over]                        <= overrun_flag; // [R4]
      line_status[uies_pkg::uies_ls_err_lo+2:uies_pkg::uies_ls_err_lo] <= rx.hold_err; // [R4]
      line_status[uies_pkg::uies_ls_thr]                         <= tx.holding_empty; // [R4]
      line_status[uies_pkg::uies_ls_temt]                        <= tx.holding_empty && tx.shift_empty; // [R4]
      line_status[uies_pkg::uies_ls_fifo]                        <= rx.any_err; // [R4]
    end
  end

  // ==========================================================================
  // Sticky interrupt sources; a new event wins over a clear in the same cycle.
  logic line_pend;
  logic timeout_pend;
  logic tx_pend;
  logic xonoff_pend;
  logic special_pend;
  logic flow_pend;
  logic wake_pend;
  logic gpio_flag;
  logic read_tx;
  logic read_special;

  assign read_tx      = is_read && (current_code == uies_pkg::uies_code_tx);
  assign read_special = is_read && (current_code == uies_pkg::uies_code_special);

  always_ff @(posedge clock) begin
    if (rst) begin
      line_pend <= 1'b0;
    end else if (line_event) begin
      line_pend <= 1'b1;
    end else if (line_status_rd) begin
      line_pend <= 1'b0; // [R16]
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      timeout_pend <= 1'b0;
    end else if (timeout_fire) begin
      timeout_pend <= 1'b1; // [R14]
    end else if (receive_holding_rd) begin
      timeout_pend <= 1'b0; // [R14]
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      tx_pend <= 1'b0;
    end else if (tx_event) begin
      tx_pend <= 1'b1; // [R15]
    end else if (read_tx || transmit_holding_wr) begin
      tx_pend <= 1'b0; // [R15]
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      xonoff_pend <= 1'b0;
    end else if (xon_match || xoff_match) begin
      xonoff_pend <= 1'b1; // [R18]
    end else if (read_special) begin
      xonoff_pend <= 1'b0; // [R18]
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      special_pend <= 1'b0;
    end else if (special_match) begin
      special_pend <= 1'b1; // [R18]
    end else if (read_special || rx.push) begin
      special_pend <= 1'b0; // [R18]
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      flow_pend <= 1'b0;
    end else if (flow_event) begin
      flow_pend <= 1'b1; // [R11]
    end else if (modem_status_rd) begin
      flow_pend <= 1'b0; // [R16]
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      wake_pend <= 1'b0;
    end else if (wake_event && cfg.wake_enable) begin
      wake_pend <= 1'b1; // [R19]
    end else if (is_read) begin
      wake_pend <= 1'b0; // [R19]
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      gpio_flag <= 1'b0;
    end else if (gpio_rise != 8'h00) begin
      gpio_flag <= 1'b1; // [R20]
    end else if (gpio_level_rd) begin
      gpio_flag <= 1'b0; // [R20]
    end
  end

  // ==========================================================================
  // Masking and priority.
  assign pend[0] = interrupt_enable[uies_pkg::uies_ie_line] && line_pend; // [R7]
  assign pend[1] = interrupt_enable[uies_pkg::uies_ie_rx] && timeout_pend && fifo_enable; // [R14]
  assign pend[2] = interrupt_enable[uies_pkg::uies_ie_rx] && rx_level_pend; // [R5]
  assign pend[3] = interrupt_enable[uies_pkg::uies_ie_tx] && tx_pend; // [R6]
  assign pend[4] = interrupt_enable[uies_pkg::uies_ie_modem] && (modem_status != 4'h0); // [R9] [R16]
  assign pend[5] = cfg.enhanced && ((interrupt_enable[uies_pkg::uies_ie_xoff] && xonoff_pend)
                                    || special_pend); // [R18]
  assign pend[6] = cfg.enhanced && flow_pend; // [R11]
  assign gpio_pend = gpio_flag;

  assign current_code = uies_encode(pend); // [R12] [R13]

  // ==========================================================================
  // Status register, frozen while a read is under way.
  always_ff @(posedge clock) begin
    if (rst) begin
      interrupt_status <= uies_pkg::uies_rst_interrupt_status;
    end else if (!is_read) begin
      interrupt_status[5:0]                   <= current_code; // [R12] [R13]
      interrupt_status[uies_pkg::uies_is_fifo] <= fifo_enable; // [R21]
      interrupt_status[uies_pkg::uies_is_gpio] <= fifo_enable ^ gpio_pend; // [R21]
    end
  end

  // ==========================================================================
  // Mode outputs and interrupt line.
  always_ff @(posedge clock) begin
    if (rst) begin
      polled_mode  <= 1'b0;
      sleep_enable <= 1'b0;
    end else begin
      polled_mode  <= fifo_enable && (interrupt_enable[3:0] == 4'h0); // [R3]
      sleep_enable <= interrupt_enable[uies_pkg::uies_ie_sleep]; // [R10]
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      irq <= 1'b0;
    end else begin
      irq <= (pend != 7'h00) || wake_pend || gpio_pend; // [R22]
    end
  end

endmodule : uies_top
`default_nettype wire

// ### verif/uies_monitor.sv
// Checker of the interrupt enable and status block.
`timescale 1ns/100ps
`default_nettype none
module uies_monitor (
  input wire logic                   clock,
  input wire logic                   rst,
  input wire logic [2:0]             reg_addr,
  input wire logic                   reg_wr,
  input wire logic                   reg_rd,
  input wire logic [7:0]             reg_wdata,
  input wire logic                   line_status_rd,
  input wire logic                   transmit_holding_wr,
  input wire logic                   fifo_enable,
  input wire uies_pkg::uies_rx_type  rx,
  input wire uies_pkg::uies_tx_type  tx,
  input wire uies_pkg::uies_cfg_type cfg,
  input wire logic [7:0]             interrupt_enable,
  input wire logic [7:0]             interrupt_status,
  input wire logic                   irq
);
  // ==========================================================================
  // Assertions.
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  wire logic ie_wr = reg_wr && reg_addr == 3'h1;
  wire logic quiet = !rx.overrun && !rx.push && !rx.hold_load && rx.hold_err == 3'h0 && !reg_rd;

  rst_values_a: assert property ($fell(rst) |-> interrupt_enable == 8'h00 && interrupt_status == 8'h01 && !irq)
    else $error("reset values wrong");
  enh_lock_a: assert property (ie_wr && !cfg.enhanced |=> $stable(interrupt_enable[7:4]))
    else $error("enable bits 7:4 changed while locked");
  low_write_a: assert property (ie_wr |=> interrupt_enable[3:0] == $past(reg_wdata[3:0]))
    else $error("enable bits 3:0 not written");
  irq_out_a: assert property (!interrupt_status[0] |-> irq)
    else $error("irq low with interrupt pending");
  fifo_bit_a: assert property ((fifo_enable && !reg_rd)[*3] |-> interrupt_status[7])
    else $error("status bit 7 low in fifo mode");
  overrun_a: assert property (rx.overrun && interrupt_enable[2] && !reg_rd ##1 !reg_rd && !line_status_rd && !ie_wr
    |-> ##1 interrupt_status[5:0] == 6'h06)
    else $error("overrun not reported");
  tx_now_a: assert property (ie_wr && reg_wdata[1] && !interrupt_enable[1] && tx.holding_empty && !fifo_enable
    && !transmit_holding_wr ##1 !reg_rd && !transmit_holding_wr && !ie_wr |-> ##1 irq)
    else $error("transmit ready not raised on enable");
  line_clear_a: assert property (line_status_rd && quiet ##1 quiet[*2] |-> interrupt_status[5:0] != 6'h06)
    else $error("line interrupt not cleared");
endmodule : uies_monitor

bind uies_top uies_monitor u_mon (.clock, .rst, .reg_addr, .reg_wr, .reg_rd, .reg_wdata, .line_status_rd,
  .transmit_holding_wr, .fifo_enable, .rx, .tx, .cfg, .interrupt_enable, .interrupt_status, .irq);
`default_nettype wire

// ### verif/uies_host.sv
// Host model issuing register accesses.
`timescale 1ns/100ps
`default_nettype none
module uies_host (
  input wire logic       clock,
  input wire logic [7:0] interrupt_status,
  output logic     [2:0] reg_addr,
  output logic           reg_wr,
  output logic           reg_rd,
  output logic     [7:0] reg_wdata
);
  // ==========================================================================
  // Accesses.
  initial begin
    reg_addr = 3'h0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_wdata = 8'h00;
  end

  task automatic wr(input logic [7:0] v);
    @(negedge clock);
    reg_addr = uies_pkg::uies_ofs_interrupt_enable;
    reg_wdata = v;
    reg_wr = 1'b1;
    @(negedge clock);
    reg_wr = 1'b0;
    reg_wdata = ~v;
  endtask : wr

  task automatic rd(output logic [7:0] v);
    @(negedge clock);
    reg_addr = uies_pkg::uies_ofs_interrupt_status;
    reg_rd = 1'b1;
    @(posedge clock);
    v = interrupt_status;
    @(negedge clock);
    reg_rd = 1'b0;
  endtask : rd
endmodule : uies_host
`default_nettype wire

// ### verif/uies_top_tb_top.sv
// Testbench of the interrupt enable and status block.
`timescale 1ns/100ps
`default_nettype none
module uies_top_tb_top;
  // ==========================================================================
  // Signals.
  logic                   clock = 1'b0;
  logic                   rst = 1'b1;
  logic [2:0]             reg_addr;
  logic                   reg_wr, reg_rd;
  logic [7:0]             reg_wdata, d;
  logic [9:0]             ev = 10'h000;
  logic                   fifo_enable = 1'b0;
  uies_pkg::uies_rx_type  rx = '0;
  uies_pkg::uies_tx_type  tx = {8'h00, 8'h01, 2'b11};
  uies_pkg::uies_cfg_type cfg = '0;
  logic [3:0]             modem_status = 4'h0;
  logic                   cts_pin = 1'b0;
  logic [7:0]             gpio_pin = 8'h01;
  logic [7:0]             gpio_int_enable = 8'h01;
  logic [7:0]             gpio_inversion = 8'h01;
  logic [7:0]             interrupt_enable, interrupt_status, line_status;
  logic                   polled_mode, sleep_enable, irq;
  int                     fails = 0;
  int                     n_compared = 0;

  always #50 clock = ~clock;

  uies_top uut (
    .clock, .rst, .reg_addr, .reg_wr, .reg_rd, .reg_wdata,
    .line_status_rd(ev[0]), .modem_status_rd(ev[1]), .receive_holding_rd(ev[2]),
    .transmit_holding_wr(ev[3]), .gpio_level_rd(ev[4]), .fifo_enable, .rx, .tx, .cfg, .modem_status,
    .bit_tick(1'b1), .char_bits(4'h8), .rts_out(ev[9]), .cts_pin, .xon_match(ev[7]), .xoff_match(ev[8]),
    .special_match(ev[6]), .wake_event(ev[5]), .gpio_pin, .gpio_int_enable, .gpio_inversion,
    .interrupt_enable, .interrupt_status, .line_status, .polled_mode, .sleep_enable, .irq
  );
  uies_host host (.clock, .interrupt_status, .reg_addr, .reg_wr, .reg_rd, .reg_wdata);

  // ==========================================================================
  // Tasks.
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    n_compared++;
    if (g !== e) begin
      fails++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask : chk

  task automatic pulse(input int i);
    @(negedge clock);
    ev[i] = 1'b1;
    @(negedge clock);
    ev[i] = 1'b0;
  endtask : pulse

  task automatic lvl(input logic [7:0] v, input logic p);
    @(negedge clock);
    rx.level = v;
    rx.pop = p;
    rx.push = !p;
    @(negedge clock);
    rx.pop = 1'b0;
    rx.push = 1'b0;
  endtask : lvl

  task automatic st(input string n, input logic [7:0] e);
    repeat (6) @(negedge clock);
    chk(n, e, interrupt_status);
  endtask : st

  task automatic end_of_test;
    if (fails == 0 && n_compared > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : end_of_test

  // ==========================================================================
  // Sequence.
  initial begin
    repeat (2) @(negedge clock);
    rst = 1'b0;
    chk("enable", 8'h00, interrupt_enable);
    chk("status", 8'h01, interrupt_status);
    chk("line", 8'h60, line_status);
    chk("irq", 8'h00, {7'h0, irq});
    host.wr(8'hff);
    chk("locked", 8'h0f, interrupt_enable);
    st("tx", 8'h02);
    chk("irq", 8'h01, {7'h0, irq});
    host.rd(d);
    chk("read", 8'h02, d);
    st("txclr", 8'h01);
    rx.overrun = 1'b1;
    lvl(8'h01, 1'b0);
    rx.overrun = 1'b0;
    st("line", 8'h06);
    chk("lsr", 8'h63, line_status);
    pulse(0);
    st("rx", 8'h04);
    lvl(8'h00, 1'b1);
    st("drain", 8'h01);
    chk("lsr", 8'h60, line_status);
    {cfg.error_at_entry, rx.push_err} = 4'h9;
    lvl(8'h01, 1'b0);
    st("entry", 8'h06);
    pulse(0);
    {cfg.error_at_entry, rx.push_err} = 4'h0;
    fifo_enable = 1'b1;
    rx.trigger = 8'h04;
    host.wr(8'h05);
    for (int i = 3; i < 5; i++) begin
      lvl(i[7:0], 1'b0);
      st("trig", (i < 4) ? 8'hc1 : 8'hc4);
    end
    lvl(8'h03, 1'b1);
    st("below", 8'hc1);
    repeat (36) @(negedge clock);
    chk("wait", 8'hc1, interrupt_status);
    repeat (12) @(negedge clock);
    chk("tmo", 8'hcc, interrupt_status);
    pulse(2);
    st("tmoclr", 8'hc1);
    host.wr(8'h00);
    st("idle", 8'hc1);
    chk("polled", 8'h01, {7'h0, polled_mode});
    gpio_pin = 8'h00;
    st("gpio", 8'h81);
    chk("irq", 8'h01, {7'h0, irq});
    pulse(4);
    st("gpioclr", 8'hc1);
    {gpio_int_enable, gpio_inversion} = 16'h0202;
    st("gpio_inversion", 8'h81);
    pulse(4);
    cfg.wake_enable = 1'b1;
    pulse(5);
    st("wake", 8'hc1);
    chk("irq", 8'h01, {7'h0, irq});
    host.rd(d);
    st("wakeclr", 8'hc1);
    chk("irq", 8'h00, {7'h0, irq});
    cfg.enhanced = 1'b1;
    pulse(6);
    st("spec", 8'hd0);
    host.rd(d);
    chk("read", 8'hd0, d);
    st("specclr", 8'hc1);
    host.wr(8'hf0);
    chk("enh", 8'hf0, interrupt_enable);
    pulse(7);
    st("xon", 8'hd0);
    chk("sleep", 8'h01, {7'h0, sleep_enable});
    host.rd(d);
    pulse(8);
    st("xoff", 8'hd0);
    host.rd(d);
    {cfg.auto_rts, cfg.auto_cts} = 2'b11;
    cts_pin = 1'b1;
    st("cts", 8'he0);
    pulse(1);
    st("ctsclr", 8'hc1);
    pulse(9);
    st("rts", 8'he0);
    pulse(1);
    st("rtsclr", 8'hc1);
    host.wr(8'h08);
    modem_status = 4'h1;
    st("modem", 8'hc0);
    modem_status = 4'h0;
    host.wr(8'h0a);
    st("txf", 8'hc2);
    pulse(3);
    st("txwr", 8'hc1);
    tx = {8'h02, 8'h01, 2'b01};
    st("txfull", 8'hc1);
    chk("lsr", 8'h01, line_status);
    tx = {8'h00, 8'h01, 2'b11};
    st("txlow", 8'hc2);
    end_of_test();
  end
endmodule : uies_top_tb_top
`default_nettype wire
